/* core/compact_ops_pkg.sv */
// constants and types shared by the compact extra-ops decoder files
package compact_ops_pkg;
    // -----------------------------------------------------------------
    // instruction encoding fields
    // -----------------------------------------------------------------
    localparam logic [1:0] OP_QUAD0    = 2'h0;
    localparam logic [1:0] OP_QUAD1    = 2'h1;
    localparam logic [5:0] F6_LOAD_B   = 6'h20;
    localparam logic [5:0] F6_LOAD_H   = 6'h21;
    localparam logic [5:0] F6_STORE_B  = 6'h22;
    localparam logic [5:0] F6_STORE_H  = 6'h23;
    localparam logic [5:0] F6_ARITH    = 6'h27;
    localparam logic [1:0] MINOR_UNARY = 2'h3;
    localparam logic [1:0] MINOR_MUL   = 2'h2;
    localparam logic [2:0] U_ZEXT_B    = 3'h0;
    localparam logic [2:0] U_SEXT_B    = 3'h1;
    localparam logic [2:0] U_ZEXT_H    = 3'h2;
    localparam logic [2:0] U_SEXT_H    = 3'h3;
    localparam logic [2:0] U_ZEXT_W    = 3'h4;
    localparam logic [2:0] U_INVERT    = 3'h5;
    localparam logic [1:0] REG_BANK    = 2'h1;
    localparam logic [1:0] SIZE_BYTE   = 2'h0;
    localparam logic [1:0] SIZE_HALF   = 2'h1;

    // -----------------------------------------------------------------
    // register map
    // -----------------------------------------------------------------
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_STATUS   = 8'h04;
    localparam logic [7:0]  ADDR_LAST_ILL = 8'h08;
    localparam logic [7:0]  ADDR_RETIRED  = 8'h0c;
    localparam logic [1:0]  CTRL_RESET    = 2'h3;
    localparam int          CTRL_MUL_BIT  = 0;
    localparam int          CTRL_SEXT_BIT = 1;
    localparam int          STAT_BUSY_BIT = 0;
    localparam int          STAT_ILL_BIT  = 1;

    // -----------------------------------------------------------------
    // states and instruction kinds
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_MEM  = 2'b10,
        ST_WB   = 2'b11
    } state_e;

    typedef enum logic [2:0] {
        K_LBU   = 3'b000,
        K_LHU   = 3'b001,
        K_LH    = 3'b010,
        K_SB    = 3'b011,
        K_SH    = 3'b100,
        K_UNARY = 3'b101,
        K_MUL   = 3'b110
    } kind_e;
endpackage

/* core/compact_exec_unit.sv */
// single-operand extend/invert and low-half multiply datapath
`timescale 1ns/1ps
module compact_exec_unit #(
    parameter int XLEN = 32
) (
    // operation select
    input  wire logic [2:0]      sel,
    input  wire logic            is_mul,
    // operands and result
    input  wire logic [XLEN-1:0] opa,
    input  wire logic [XLEN-1:0] opb,
    output logic      [XLEN-1:0] result
);
    // full signed product, only the low half is kept
    logic signed [2*XLEN-1:0] product;
    assign product = $signed(opa) * $signed(opb); // RQ17

    // extension cases are casts so one body serves both widths
    always_comb begin
        result = opa;
        if (is_mul) begin
            result = product[XLEN-1:0]; // RQ17
        end else begin
            unique case (sel)
                compact_ops_pkg::U_ZEXT_B: result = XLEN'(opa[7:0]); // RQ11
                compact_ops_pkg::U_SEXT_B: result = XLEN'($signed(opa[7:0])); // RQ12
                compact_ops_pkg::U_ZEXT_H: result = XLEN'(opa[15:0]); // RQ13
                compact_ops_pkg::U_SEXT_H: result = XLEN'($signed(opa[15:0])); // RQ14
                compact_ops_pkg::U_ZEXT_W: result = XLEN'(opa[31:0]); // RQ15
                compact_ops_pkg::U_INVERT: result = opa ^ {XLEN{1'b1}}; // RQ16
                default:                   result = opa;
            endcase
        end
    end
endmodule

/* core/compact_extra_ops_decode_execute.sv */
// decoder and sequencer for the compact load/store, extend, invert, multiply group
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
// How it works
// RQ1: byte load/store offset is {instr[5], instr[6]}, upper bits zero.
// RQ2: halfword offset is {instr[5], 0}; bit 6 signed for loads, zero for stores.
// RQ3: bits 15:10 100000/100001/100010/100011 select the four load/store forms, bits 1:0 00.
// RQ4: byte load reads base plus offset, zero-extends, writes destination.
// RQ5: unsigned halfword load zero-extends the loaded halfword into destination.
// RQ6: signed halfword load sign-extends the loaded halfword into destination.
// RQ7: byte store writes only the low 8 bits of the source.
// RQ8: halfword store writes only the low 16 bits of the source.
// RQ9: every 3-bit register field means register 8 plus field.
// RQ10: unary forms: 100111, register 9:7, 6:5 = 11, 1:0 = 01, op in 4:2.
// RQ11: byte zero-extend keeps bits 7:0, clears the rest, writes back.
// RQ12: byte sign-extend copies bit 7 upward, writes back.
// RQ13: halfword zero-extend keeps bits 15:0, clears the rest.
// RQ14: halfword sign-extend copies bit 15 upward.
// RQ15: word zero-extend, 64-bit only, clears bits above 31.
// RQ16: invert replaces the register with its complement.
// RQ17: multiply signed operands, keep low native-width half in first register.
// RQ18: multiply: 100111, register 9:7, 6:5 = 10, second in 4:2, 1:0 = 01.
// RQ19: multiply only with a multiply extension present.
// RQ20: byte sign-extend only with the bit-manipulation extension present.
// RQ21: the whole group needs the base compressed subset.
// RQ22: unavailable forms are reported as illegal instructions.
module compact_extra_ops_decode_execute #(
    parameter int XLEN            = 32,
    parameter bit HAS_COMPRESSED  = 1'b1,
    parameter bit HAS_MULTIPLY    = 1'b1,
    parameter bit HAS_BITMANIP    = 1'b1
) (
    // clock and reset
    input  wire logic            mclk,
    input  wire logic            nrst,
    // apb register port
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    // issue side
    input  wire logic            instr_valid,
    input  wire logic [15:0]     instr,
    output logic                 instr_ready,
    output logic                 illegal_instr,
    output logic                 retire,
    // register file
    output logic      [4:0]      rf_raddr_a,
    output logic      [4:0]      rf_raddr_b,
    input  wire logic [XLEN-1:0] rf_rdata_a,
    input  wire logic [XLEN-1:0] rf_rdata_b,
    output logic                 rf_we,
    output logic      [4:0]      rf_waddr,
    output logic      [XLEN-1:0] rf_wdata,
    // memory path
    output logic                 mem_req,
    output logic                 mem_we,
    output logic      [1:0]      mem_size,
    output logic      [XLEN-1:0] mem_addr,
    output logic      [XLEN-1:0] mem_wdata,
    input  wire logic            mem_ack,
    input  wire logic [XLEN-1:0] mem_rdata
);
    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    compact_ops_pkg::state_e state_q;
    compact_ops_pkg::kind_e  kind_q;
    logic [2:0]      usel_q;
    logic [1:0]      off_q;
    logic [1:0]      ctrl_q;
    logic            ill_sticky_q;
    logic [15:0]     last_ill_q;
    logic [31:0]     retired_q;
    logic            ready_q;
    logic            illegal_q;
    logic            retire_q;
    logic [4:0]      ra_a_q;
    logic [4:0]      ra_b_q;
    logic            we_q;
    logic [4:0]      wa_q;
    logic [XLEN-1:0] wd_q;
    logic            req_q;
    logic            mwe_q;
    logic [1:0]      size_q;
    logic [XLEN-1:0] maddr_q;
    logic [XLEN-1:0] mwd_q;
    logic [31:0]     prdata_q;
    logic            pready_q;
    logic            pslverr_q;

    // -----------------------------------------------------------------
    // decode
    // -----------------------------------------------------------------
    // feature gates: multiply and byte sign-extend need both hardware option and software enable
    wire        has_c     = HAS_COMPRESSED; // RQ21
    wire        mul_ok    = HAS_MULTIPLY & ctrl_q[compact_ops_pkg::CTRL_MUL_BIT]; // RQ19
    wire        sext_ok   = HAS_BITMANIP & ctrl_q[compact_ops_pkg::CTRL_SEXT_BIT]; // RQ20
    wire        wide_core = (XLEN == 64);
    wire [5:0]  f6        = instr[15:10];
    wire [2:0]  uop       = instr[4:2];
    wire        quad0     = has_c && (instr[1:0] == compact_ops_pkg::OP_QUAD0);
    wire        quad1     = has_c && (instr[1:0] == compact_ops_pkg::OP_QUAD1);
    wire        dec_lbu   = quad0 && (f6 == compact_ops_pkg::F6_LOAD_B); // RQ3
    wire        dec_lh    = quad0 && (f6 == compact_ops_pkg::F6_LOAD_H); // RQ3
    wire        dec_sb    = quad0 && (f6 == compact_ops_pkg::F6_STORE_B); // RQ3
    // a halfword store with bit 6 set is not a defined encoding
    wire        dec_sh    = quad0 && (f6 == compact_ops_pkg::F6_STORE_H) && !instr[6]; // RQ2
    wire        arith     = quad1 && (f6 == compact_ops_pkg::F6_ARITH);
    wire        unary_enc = arith && (instr[6:5] == compact_ops_pkg::MINOR_UNARY); // RQ10
    wire        dec_unary = unary_enc && (uop <= compact_ops_pkg::U_INVERT)
                            && (uop != compact_ops_pkg::U_ZEXT_W || wide_core) // RQ15
                            && (uop != compact_ops_pkg::U_SEXT_B || sext_ok); // RQ20
    wire        dec_mul   = arith && (instr[6:5] == compact_ops_pkg::MINOR_MUL) && mul_ok; // RQ18
    wire        dec_legal = dec_lbu | dec_lh | dec_sb | dec_sh | dec_unary | dec_mul;
    wire        take      = instr_valid && ready_q;

    // kind, offset and register numbers of the instruction on offer
    wire compact_ops_pkg::kind_e dec_kind =
        dec_lbu   ? compact_ops_pkg::K_LBU :
        dec_lh    ? (instr[6] ? compact_ops_pkg::K_LH : compact_ops_pkg::K_LHU) : // RQ2
        dec_sb    ? compact_ops_pkg::K_SB :
        dec_sh    ? compact_ops_pkg::K_SH :
        dec_unary ? compact_ops_pkg::K_UNARY : compact_ops_pkg::K_MUL;
    wire        byte_form = dec_lbu | dec_sb;
    wire [1:0]  dec_off   = byte_form ? {instr[5], instr[6]} // RQ1
                                      : {instr[5], 1'b0}; // RQ2
    wire        is_mem    = quad0;
    wire [4:0]  reg_hi    = {compact_ops_pkg::REG_BANK, instr[9:7]}; // RQ9
    wire [4:0]  reg_lo    = {compact_ops_pkg::REG_BANK, instr[4:2]}; // RQ9
    wire [4:0]  dec_dst   = is_mem ? reg_lo : reg_hi;

    // -----------------------------------------------------------------
    // execute datapath
    // -----------------------------------------------------------------
    logic [XLEN-1:0] alu_res;

    compact_exec_unit #(
        .XLEN   (XLEN)
    ) u_exec (
        .sel    (usel_q),
        .is_mul (kind_q == compact_ops_pkg::K_MUL),
        .opa    (rf_rdata_a),
        .opb    (rf_rdata_b),
        .result (alu_res)
    );

    // load data shaping and store data trimming
    wire [XLEN-1:0] ld_byte_u = XLEN'(mem_rdata[7:0]); // RQ4
    wire [XLEN-1:0] ld_half_u = XLEN'(mem_rdata[15:0]); // RQ5
    wire [XLEN-1:0] ld_half_s = XLEN'($signed(mem_rdata[15:0])); // RQ6
    wire [XLEN-1:0] ld_val    = (kind_q == compact_ops_pkg::K_LBU) ? ld_byte_u :
                                (kind_q == compact_ops_pkg::K_LHU) ? ld_half_u : ld_half_s;
    wire            st_byte   = (kind_q == compact_ops_pkg::K_SB);
    wire [XLEN-1:0] st_val    = st_byte ? XLEN'(rf_rdata_b[7:0]) // RQ7
                                        : XLEN'(rf_rdata_b[15:0]); // RQ8
    wire            kind_mem  = (kind_q <= compact_ops_pkg::K_SH);
    wire            kind_st   = (kind_q == compact_ops_pkg::K_SB)
                                || (kind_q == compact_ops_pkg::K_SH);
    wire [XLEN-1:0] eff_addr  = rf_rdata_a + XLEN'(off_q); // RQ4

    // -----------------------------------------------------------------
    // sequencer
    // -----------------------------------------------------------------
    // one instruction in flight; ready is low only while one is busy and until the first clock after reset
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_q   <= compact_ops_pkg::ST_IDLE;
            kind_q    <= compact_ops_pkg::K_LBU;
            usel_q    <= 3'h0;
            off_q     <= 2'h0;
            ready_q   <= 1'b0;
            illegal_q <= 1'b0;
            retire_q  <= 1'b0;
            ra_a_q    <= 5'h00;
            ra_b_q    <= 5'h00;
            we_q      <= 1'b0;
            wa_q      <= 5'h00;
            wd_q      <= '0;
            req_q     <= 1'b0;
            mwe_q     <= 1'b0;
            size_q    <= compact_ops_pkg::SIZE_BYTE;
            maddr_q   <= '0;
            mwd_q     <= '0;
        end else begin
            illegal_q <= 1'b0;
            retire_q  <= 1'b0;
            we_q      <= 1'b0;
            unique case (state_q)
                compact_ops_pkg::ST_IDLE: begin
                    ready_q <= 1'b1;
                    if (take && !dec_legal) begin
                        illegal_q <= 1'b1; // RQ22
                    end else if (take) begin
                        ready_q <= 1'b0;
                        kind_q  <= dec_kind;
                        usel_q  <= uop;
                        off_q   <= dec_off;
                        ra_a_q  <= reg_hi;
                        ra_b_q  <= reg_lo;
                        wa_q    <= dec_dst;
                        state_q <= compact_ops_pkg::ST_READ;
                    end
                end
                compact_ops_pkg::ST_READ: begin
                    if (kind_mem) begin
                        req_q   <= 1'b1;
                        mwe_q   <= kind_st;
                        size_q  <= (kind_q == compact_ops_pkg::K_LBU || st_byte)
                                   ? compact_ops_pkg::SIZE_BYTE
                                   : compact_ops_pkg::SIZE_HALF;
                        maddr_q <= eff_addr;
                        mwd_q   <= kind_st ? st_val : '0;
                        state_q <= compact_ops_pkg::ST_MEM;
                    end else begin
                        we_q    <= 1'b1; // RQ10
                        wd_q    <= alu_res;
                        state_q <= compact_ops_pkg::ST_WB;
                    end
                end
                compact_ops_pkg::ST_MEM: begin
                    if (mem_ack) begin
                        req_q <= 1'b0;
                        if (mwe_q) begin
                            retire_q <= 1'b1;
                            ready_q  <= 1'b1;
                            state_q  <= compact_ops_pkg::ST_IDLE;
                        end else begin
                            we_q    <= 1'b1;
                            wd_q    <= ld_val;
                            state_q <= compact_ops_pkg::ST_WB;
                        end
                    end
                end
                compact_ops_pkg::ST_WB: begin
                    retire_q <= 1'b1;
                    ready_q  <= 1'b1;
                    state_q  <= compact_ops_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // apb register slave
    // -----------------------------------------------------------------
    // zero-wait: read data is sampled in setup, write data in the access, pready rises for the access
    wire        apb_setup = psel && !penable;
    wire        apb_wr    = psel && penable && pwrite && pready_q;
    wire        hit_ctrl  = (paddr == compact_ops_pkg::ADDR_CTRL);
    wire        hit_stat  = (paddr == compact_ops_pkg::ADDR_STATUS);
    wire        hit_last  = (paddr == compact_ops_pkg::ADDR_LAST_ILL);
    wire        hit_ret   = (paddr == compact_ops_pkg::ADDR_RETIRED);
    wire        hit_any   = hit_ctrl | hit_stat | hit_last | hit_ret;
    wire        busy      = (state_q != compact_ops_pkg::ST_IDLE);
    wire [31:0] rd_mux    = hit_ctrl ? {30'h0, ctrl_q} :
                            hit_stat ? {30'h0, ill_sticky_q, busy} :
                            hit_last ? {16'h0, last_ill_q} :
                            hit_ret  ? retired_q : 32'h0;
    wire        ill_clr   = apb_wr && hit_stat && pwdata[compact_ops_pkg::STAT_ILL_BIT];
    wire        ill_event = take && !dec_legal && (state_q == compact_ops_pkg::ST_IDLE);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end else begin
            pready_q  <= apb_setup;
            pslverr_q <= apb_setup && !hit_any;
            prdata_q  <= (apb_setup && !pwrite) ? rd_mux : 32'h0;
        end
    end

    // software state; a new illegal event beats a clear in the same cycle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q       <= compact_ops_pkg::CTRL_RESET;
            ill_sticky_q <= 1'b0;
            last_ill_q   <= 16'h0;
            retired_q    <= 32'h0;
        end else begin
            if (apb_wr && hit_ctrl) begin
                ctrl_q <= pwdata[1:0];
            end
            if (ill_event) begin
                ill_sticky_q <= 1'b1; // RQ22
                last_ill_q   <= instr;
            end else if (ill_clr) begin
                ill_sticky_q <= 1'b0;
            end
            if (retire_q) begin
                retired_q <= retired_q + 32'h1;
            end
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    assign prdata        = prdata_q;
    assign pready        = pready_q;
    assign pslverr       = pslverr_q;
    assign instr_ready   = ready_q;
    assign illegal_instr = illegal_q;
    assign retire        = retire_q;
    assign rf_raddr_a    = ra_a_q;
    assign rf_raddr_b    = ra_b_q;
    assign rf_we         = we_q;
    assign rf_waddr      = wa_q;
    assign rf_wdata      = wd_q;
    assign mem_req       = req_q;
    assign mem_we        = mwe_q;
    assign mem_size      = size_q;
    assign mem_addr      = maddr_q;
    assign mem_wdata     = mwd_q;

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    wire in_read = (state_q == compact_ops_pkg::ST_READ);

    sequence load_done_s;
        (state_q == compact_ops_pkg::ST_MEM) && mem_ack && !mwe_q;
    endsequence

    sequence writeback_s;
        rf_we ##1 !rf_we && retire;
    endsequence

    // the offered encoding is gone by the read cycle, so check the offset at the take
    byte_offset_a: assert property ( // RQ1
        take && (dec_lbu || dec_sb) |=> off_q == {$past(instr[5]), $past(instr[6])})
        else $error("byte offset bits not taken from bits 5 and 6");

    half_offset_a: assert property ( // RQ2
        take && dec_legal && (dec_lh || dec_sh) |=> off_q == {$past(instr[5]), 1'b0})
        else $error("halfword offset bit 0 not zero");

    load_kind_a: assert property ( // RQ3
        take && quad0 && f6 == compact_ops_pkg::F6_LOAD_B && state_q == compact_ops_pkg::ST_IDLE
        |=> kind_q == compact_ops_pkg::K_LBU)
        else $error("byte load not recognised");

    lbu_fill_a: assert property ( // RQ4
        load_done_s and (kind_q == compact_ops_pkg::K_LBU)
        |=> rf_wdata == XLEN'($past(mem_rdata[7:0])))
        else $error("byte load not zero extended");

    lh_sign_a: assert property ( // RQ6
        load_done_s and (kind_q == compact_ops_pkg::K_LH)
        |=> rf_wdata[XLEN-1:16] == {(XLEN-16){rf_wdata[15]}})
        else $error("halfword load not sign extended");

    load_wb_a: assert property ( // RQ5
        load_done_s |=> writeback_s)
        else $error("load did not write back then retire");

    sb_trim_a: assert property ( // RQ7
        $rose(mem_req) && mem_we && mem_size == compact_ops_pkg::SIZE_BYTE
        |-> mem_wdata[XLEN-1:8] == '0)
        else $error("byte store carries upper bits");

    reg_bank_a: assert property ( // RQ9
        take && dec_legal && !busy |=> rf_raddr_a[4:3] == compact_ops_pkg::REG_BANK
        && rf_raddr_b[4:3] == compact_ops_pkg::REG_BANK)
        else $error("register field outside x8 to x15");

    invert_a: assert property ( // RQ16
        in_read && kind_q == compact_ops_pkg::K_UNARY && usel_q == compact_ops_pkg::U_INVERT
        |=> rf_we && rf_wdata == ~$past(rf_rdata_a) && rf_waddr == rf_raddr_a)
        else $error("invert result or target wrong");

    illegal_a: assert property ( // RQ22
        take && !busy && !dec_legal |=> illegal_instr && !rf_we ##1 !illegal_instr)
        else $error("unavailable form not flagged once");
endmodule

/* verification/compact_far_model.sv */
// register file and memory path model facing the compact ops block
`timescale 1ns/1ps
module compact_far_model #(
    parameter int XLEN = 32
) (
    // clock, reset, memory answer delay
    input  wire logic            mclk,
    input  wire logic            nrst,
    input  wire logic [1:0]      delay,
    // register file
    input  wire logic [4:0]      rf_raddr_a,
    input  wire logic [4:0]      rf_raddr_b,
    output logic      [XLEN-1:0] rf_rdata_a,
    output logic      [XLEN-1:0] rf_rdata_b,
    input  wire logic            rf_we,
    input  wire logic [4:0]      rf_waddr,
    input  wire logic [XLEN-1:0] rf_wdata,
    // memory path
    input  wire logic            mem_req,
    input  wire logic            mem_we,
    input  wire logic [1:0]      mem_size,
    input  wire logic [XLEN-1:0] mem_addr,
    input  wire logic [XLEN-1:0] mem_wdata,
    output logic                 mem_ack,
    output logic      [XLEN-1:0] mem_rdata
);
    logic [XLEN-1:0] regs [0:31];
    logic [XLEN-1:0] w_data, s_data, s_addr;
    logic [4:0]      w_addr;
    logic [1:0]      cnt_q, s_size;
    int              wr_cnt = 0;
    int              st_cnt = 0;
    // combinational reads, sampled in the same cycle
    assign rf_rdata_a = regs[rf_raddr_a];
    assign rf_rdata_b = regs[rf_raddr_b];
    // full-width pattern, inverted outside ack
    assign mem_rdata = (mem_addr * 32'h9e3779b1) ^ {XLEN{!mem_ack}};
    // ack after delay idle cycles, one cycle wide
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mem_ack <= 1'b0;
            cnt_q   <= 2'h0;
        end else begin
            mem_ack <= mem_req && !mem_ack && cnt_q == delay;
            cnt_q   <= (mem_req && !mem_ack && cnt_q != delay) ? cnt_q + 2'h1 : 2'h0;
            if (rf_we) begin
                w_addr <= rf_waddr;
                w_data <= rf_wdata;
                wr_cnt <= wr_cnt + 1;
            end
            if (mem_req && mem_ack && mem_we) begin
                s_addr <= mem_addr;
                s_data <= mem_wdata;
                s_size <= mem_size;
                st_cnt <= st_cnt + 1;
            end
        end
    end
endmodule

/* verification/compact_extra_ops_decode_execute_tb.sv */
// self-checking bench for the compact extra-ops decoder
`timescale 1ns/1ps
module compact_extra_ops_decode_execute_tb;
    logic        mclk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, instr_valid = 0, er;
    logic        pready, pslverr, instr_ready, illegal_instr, retire, rf_we, mem_req, mem_we, mem_ack;
    logic [7:0]  paddr = 0;
    logic [15:0] instr = 0;
    logic [1:0]  mem_size, delay = 0;
    logic [4:0]  rf_raddr_a, rf_raddr_b, rf_waddr;
    logic [31:0] pwdata = 0, prdata, rd, rf_rdata_a, rf_rdata_b, rf_wdata;
    logic [31:0] mem_addr, mem_wdata, mem_rdata, r;
    int          fails = 0, num_checks = 0, cyc = 0, legal = 0;
    compact_extra_ops_decode_execute u_compact_extra_ops_decode_execute (.*);
    compact_far_model u_compact_far_model (.*);
    // 20 mhz clock
    initial forever #25 mclk = ~mclk;
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // a hang counts as a mismatch
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 60000) begin
            fails++;
            report_and_stop;
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata; er = pslverr; psel <= 0; penable <= 0;
        @(posedge mclk);
    endtask
    // offer one encoding with random operands and check all its effects
    task automatic run(input logic [15:0] i, input logic [1:0] ctl);
        logic [31:0] a, b, ex, ad, h;
        logic [5:0]  f6;
        logic [2:0]  s;
        logic        il, ld, st, un, g;
        int          w0, s0, n;
        u_compact_far_model.regs[{2'h1, i[9:7]}] = $urandom;
        u_compact_far_model.regs[{2'h1, i[4:2]}] = $urandom;
        a = u_compact_far_model.regs[{2'h1, i[9:7]}];
        b = u_compact_far_model.regs[{2'h1, i[4:2]}];
        f6 = i[15:10]; s = i[4:2];
        ad = a + (f6[0] ? {i[5], 1'b0} : {i[5], i[6]});
        h = ad * 32'h9e3779b1;
        ld = i[1:0] == 0 && (f6 == 6'h20 || f6 == 6'h21);
        st = i[1:0] == 0 && (f6 == 6'h22 || f6 == 6'h23 && !i[6]);
        un = i[1:0] == 1 && f6 == 6'h27;
        il = !(ld || st || un && (i[6:5] == 2 && ctl[0] || i[6:5] == 3
             && (s inside {0, 2, 3, 5} || s == 1 && ctl[1])));
        case (s)
            0: ex = {24'h0, a[7:0]};
            1: ex = {{24{a[7]}}, a[7:0]};
            2: ex = {16'h0, a[15:0]};
            3: ex = {{16{a[15]}}, a[15:0]};
            default: ex = ~a;
        endcase
        // signed and unsigned low halves agree
        if (i[6:5] == 2) ex = a * b;
        if (ld) ex = f6[0] ? {{16{h[15] & i[6]}}, h[15:0]} : {24'h0, h[7:0]};
        w0 = u_compact_far_model.wr_cnt; s0 = u_compact_far_model.st_cnt; n = 0;
        while (instr_ready !== 1'b1) @(posedge mclk);
        instr_valid <= 1; instr <= i; delay <= 2'($urandom);
        @(posedge mclk);
        instr_valid <= 0;
        do begin @(posedge mclk); n++; end while (!(retire || illegal_instr) && n < 40);
        g = illegal_instr;
        repeat (2) @(posedge mclk);
        chk("illegal", il, g);
        chk("writes", w0 + (il || st ? 0 : 1), u_compact_far_model.wr_cnt);
        chk("stores", s0 + (st ? 1 : 0), u_compact_far_model.st_cnt);
        if (!il) legal++;
        if (!il && !st) begin
            chk("waddr", {2'h1, ld ? i[4:2] : i[9:7]}, u_compact_far_model.w_addr);
            chk("wdata", ex, u_compact_far_model.w_data);
        end
        if (st) begin
            chk("saddr", ad, u_compact_far_model.s_addr);
            chk("sdata", f6[0] ? {16'h0, b[15:0]} : {24'h0, b[7:0]}, u_compact_far_model.s_data);
            chk("ssize", f6[0], u_compact_far_model.s_size);
        end
    endtask
    initial begin
        void'($urandom(87079));
        repeat (8) @(posedge mclk);
        nrst <= 1;
        repeat (2) @(posedge mclk);
        apb(0, compact_ops_pkg::ADDR_CTRL, 0);
        chk("ctrl", 32'(compact_ops_pkg::CTRL_RESET), rd);
        apb(0, 8'h40, 0);
        chk("slverr", 1, er);
        for (int k = 0; k < 300; k++) begin
            r = $urandom;
            if (r[18:16] < 4) run({6'h20 | 6'(r[17:16]), r[9:2], 2'h0}, 2'h3);
            else if (r[18:16] < 7) run({6'h27, r[9:7], 1'b1, r[5:2], 2'h1}, 2'h3);
            else run(r[15:0], 2'h3);
        end
        // both features switched off: byte sign-extend and multiply refused
        apb(1, compact_ops_pkg::ADDR_CTRL, 0);
        run(16'h9c65, 2'h0);
        run(16'h9c41, 2'h0);
        apb(1, compact_ops_pkg::ADDR_CTRL, 3);
        run(16'h9c65, 2'h3);
        apb(0, compact_ops_pkg::ADDR_RETIRED, 0);
        chk("retired", legal, rd);
        report_and_stop;
    end
endmodule
